// ===== include/fbr_cfg.svh
`ifndef FBR_CFG_SVH
`define FBR_CFG_SVH
`define FBR_ADDR_W 21
`define FBR_DATA_W 16
`define FBR_PART_LSB 18
`define FBR_PART_MSB 20
`define FBR_NPART 8
`define FBR_SR_W 8
`define FBR_SR_RESET 8'h80
`define FBR_CMD_ARRAY 8'hff
`define FBR_CMD_STATUS 8'h70
`define FBR_CMD_IDENT 8'h90
`define FBR_CMD_QUERY 8'h98
`define FBR_CLK_MHZ 10
`define FBR_LATENCY 3'h2
`define FBR_LEN_4 2'h0
`define FBR_LEN_8 2'h1
`define FBR_LEN_16 2'h2
`define FBR_LEN_CONT 2'h3
`define FBR_MASK_4 21'h000003
`define FBR_MASK_8 21'h000007
`define FBR_MASK_16 21'h00000f
`define FBR_WAKE_W 12
`define FBR_BUF_DEPTH 2
`endif

// ===== include/fbr_pkg.sv
`include "fbr_cfg.svh"
package fbr_pkg;
    typedef enum logic [1:0] {
        FBR_MODE_ARRAY = 2'b00,
        FBR_MODE_IDENT = 2'b01,
        FBR_MODE_QUERY = 2'b10,
        FBR_MODE_STATUS = 2'b11
    } fbr_mode_t;
    typedef enum logic [1:0] {
        FBR_B_IDLE = 2'b00,
        FBR_B_LAT = 2'b01,
        FBR_B_DATA = 2'b10
    } fbr_burst_t;
    typedef struct packed {
        logic rcfg_sync;
        logic rcfg_fall;
        logic [1:0] rcfg_len;
        fbr_mode_t [`FBR_NPART-1:0] mode;
        logic [`FBR_NPART-1:0][`FBR_SR_W-1:0] status;
        logic [`FBR_ADDR_W-1:0] addr;
        fbr_burst_t bstate;
        logic [2:0] lat;
        logic hclk_q;
        logic adv_q;
        logic adv_done;
        logic we_q;
        logic [`FBR_WAKE_W-1:0] wake;
        logic out_ok;
        logic wr_ok;
        logic [`FBR_DATA_W-1:0] data_out;
        logic data_oe;
        logic wait_busy;
        logic wait_oe;
        logic [`FBR_ADDR_W-1:0] array_addr;
        fbr_mode_t info_sel;
        logic [`FBR_BUF_DEPTH-1:0][`FBR_ADDR_W-1:0] buf_addr;
        logic [`FBR_BUF_DEPTH-1:0][`FBR_DATA_W-1:0] buf_data;
        logic [`FBR_BUF_DEPTH-1:0] buf_vld;
        logic write_ready;
        logic abort;
    } fbr_state_t;
endpackage

// ===== rtl/fbr_flash_bus.sv
// Behaviour
// RL1: burst lengths four, eight, sixteen, continuous
// RL2: burst address advances on host clock edges
// RL3: identifier mode returns identifier data only
// RL4: query mode returns query data only
// RL5: status mode returns addressed partition status
// RL6: non-array reads single cycle, wait asserted
// RL7: wait meaningful only for synchronous array reads
// RL8: read mode changes only by command
// RL9: reset gives array mode, status 80h, async
// RL10: partition decoded from upper address bits
// RL11: address valid opens latch, enable drives data
// RL12: async mode latches address on valid release
// RL13: sync latch at valid rise or edge
// RL14: host keeps write enable, reset high reading
// RL15: async-only host ties clock high, valid low
// RL16: halted clock, output disabled pauses burst
// RL17: suspended burst keeps its latched state
// RL18: resume continues from the stopped word
// RL19: wait gated by chip select only
// RL20: chip select high floats outputs, engine continues
// RL21: reset floats outputs, wake-up delays follow
// RL22: reset aborts program or erase
// RL23: host holds reset low 100 ns minimum
// RL24: write cycle captures data, ignores clock
// RL25: output disable floats the data outputs
`timescale 1ns/1ps
`default_nettype none
module fbr_flash_bus
    import fbr_pkg::*;
#(
    parameter int OUT_DELAY_NS = 150,
    parameter int WR_DELAY_NS = 150
) (
    // clock and reset pin
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // host bus pins
    input wire logic i_host_clk,
    input wire logic i_address_valid_n,
    input wire logic i_chip_sel_n,
    input wire logic i_out_en_n,
    input wire logic i_write_en_n,
    input wire logic [`FBR_ADDR_W-1:0] i_addr,
    input wire logic [`FBR_DATA_W-1:0] i_data,
    output logic [`FBR_DATA_W-1:0] o_data,
    output logic o_data_oe,
    output logic o_wait,
    output logic o_wait_oe,
    // read configuration load
    input wire logic i_rcfg_load,
    input wire logic i_rcfg_sync,
    input wire logic i_rcfg_fall,
    input wire logic [1:0] i_rcfg_len,
    // array and information sources
    output logic [`FBR_ADDR_W-1:0] o_array_addr,
    output fbr_mode_t o_info_sel,
    input wire logic [`FBR_DATA_W-1:0] i_array_data,
    input wire logic [`FBR_DATA_W-1:0] i_info_data,
    // status updates from the program_erase_engine
    input wire logic i_status_we,
    input wire logic [2:0] i_status_part,
    input wire logic [`FBR_SR_W-1:0] i_status_val,
    // command words to the program_erase_engine
    output logic o_cmd_valid,
    output logic [`FBR_ADDR_W-1:0] o_cmd_addr,
    output logic [`FBR_DATA_W-1:0] o_cmd_data,
    input wire logic i_cmd_ready,
    output logic o_write_ready,
    output logic o_engine_abort
);
    localparam int OUT_CYC_RAW = (OUT_DELAY_NS * `FBR_CLK_MHZ + 999) / 1000;
    localparam int WR_CYC_RAW = (WR_DELAY_NS * `FBR_CLK_MHZ + 999) / 1000;
    // at least one edge of wake-up, even for a zero delay
    localparam logic [`FBR_WAKE_W-1:0] OUT_CYC =
        `FBR_WAKE_W'((OUT_CYC_RAW < 1) ? 1 : OUT_CYC_RAW);
    localparam logic [`FBR_WAKE_W-1:0] WR_CYC =
        `FBR_WAKE_W'((WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW);

    fbr_state_t s;
    fbr_state_t n;

    function automatic logic [2:0] part_of(input logic [`FBR_ADDR_W-1:0] a);
        part_of = a[`FBR_PART_MSB:`FBR_PART_LSB];
    endfunction

    // wraps inside an aligned group; continuous runs linear
    function automatic logic [`FBR_ADDR_W-1:0] burst_step(
        input logic [`FBR_ADDR_W-1:0] a,
        input logic [1:0] len
    );
        logic [`FBR_ADDR_W-1:0] m;
        logic [`FBR_ADDR_W-1:0] inc;
        begin
            inc = a + 21'h000001;
            case (len)
                `FBR_LEN_4: m = `FBR_MASK_4;
                `FBR_LEN_8: m = `FBR_MASK_8;
                `FBR_LEN_16: m = `FBR_MASK_16;
                default: m = ~21'h000000;
            endcase
            burst_step = (a & ~m) | (inc & m);
        end
    endfunction

    logic hclk_edge;
    logic adv_rise;
    logic adv_fall;
    logic wr_ev;
    logic cmd_pop;
    logic latch_ev;
    fbr_mode_t cur_mode;
    fbr_mode_t new_mode;
    logic [`FBR_DATA_W-1:0] src;

    always_comb begin
        n = s;
        hclk_edge = s.rcfg_fall ? (s.hclk_q & ~i_host_clk) : (~s.hclk_q & i_host_clk);
        adv_rise = ~s.adv_q & i_address_valid_n;
        adv_fall = s.adv_q & ~i_address_valid_n;
        n.hclk_q = i_host_clk;
        n.adv_q = i_address_valid_n;
        n.we_q = i_write_en_n;
        n.abort = 1'b0;

        // wake-up counters after reset release
        if (s.wake != ~12'h000) begin
            n.wake = s.wake + 12'h001;
        end
        n.out_ok = s.out_ok | (n.wake >= OUT_CYC); // see RL21
        n.wr_ok = s.wr_ok | (n.wake >= WR_CYC); // see RL21

        if (i_rcfg_load) begin
            n.rcfg_sync = i_rcfg_sync;
            n.rcfg_fall = i_rcfg_fall;
            n.rcfg_len = i_rcfg_len; // see RL1
        end

        for (int p = 0; p < `FBR_NPART; p++) begin
            if (i_status_we && i_status_part == 3'(p)) begin
                n.status[p] = i_status_val;
            end
        end

        // write cycle on write enable rise, host clock not looked at
        wr_ev = ~s.we_q & i_write_en_n & ~i_chip_sel_n & i_out_en_n & s.wr_ok; // see RL24
        new_mode = s.mode[part_of(i_addr)];
        case (i_data[7:0])
            `FBR_CMD_ARRAY: new_mode = FBR_MODE_ARRAY;
            `FBR_CMD_STATUS: new_mode = FBR_MODE_STATUS;
            `FBR_CMD_IDENT: new_mode = FBR_MODE_IDENT;
            `FBR_CMD_QUERY: new_mode = FBR_MODE_QUERY;
            default: new_mode = s.mode[part_of(i_addr)];
        endcase
        if (wr_ev) begin
            n.mode[part_of(i_addr)] = new_mode; // see RL8
        end

        // two-entry command buffer, head always in slot 0
        cmd_pop = s.buf_vld[0] & i_cmd_ready;
        if (cmd_pop) begin
            n.buf_addr[0] = s.buf_addr[1];
            n.buf_data[0] = s.buf_data[1];
            n.buf_vld[0] = s.buf_vld[1];
            n.buf_vld[1] = 1'b0;
        end
        // drained even while deselected so the engine keeps going
        if (wr_ev) begin // see RL20
            if (!n.buf_vld[0]) begin
                n.buf_addr[0] = i_addr;
                n.buf_data[0] = i_data;
                n.buf_vld[0] = 1'b1;
            end else if (!n.buf_vld[1]) begin
                n.buf_addr[1] = i_addr;
                n.buf_data[1] = i_data;
                n.buf_vld[1] = 1'b1;
            end
        end
        n.write_ready = ~n.buf_vld[1];

        // address latch and burst sequencing
        if (adv_fall) begin
            n.adv_done = 1'b0;
        end
        latch_ev = ~i_chip_sel_n & ~s.adv_done
            & (adv_rise | (hclk_edge & ~i_address_valid_n)); // see RL13
        if (i_chip_sel_n) begin
            n.bstate = FBR_B_IDLE;
        end else if (!s.rcfg_sync) begin
            n.bstate = FBR_B_IDLE;
            if (!i_address_valid_n) begin
                n.addr = i_addr; // see RL11
            end
            // holding on the rise keeps the last transparent address
            if (adv_rise) begin
                n.adv_done = 1'b1; // see RL12
            end
        end else if (latch_ev) begin
            n.addr = i_addr;
            n.adv_done = 1'b1;
            n.lat = `FBR_LATENCY;
            // non-array modes never burst
            n.bstate = (s.mode[part_of(i_addr)] == FBR_MODE_ARRAY) ?
                FBR_B_LAT : FBR_B_IDLE; // see RL6
        end else begin
            case (s.bstate)
                FBR_B_IDLE: n.bstate = FBR_B_IDLE;
                FBR_B_LAT: begin
                    if (hclk_edge) begin
                        if (s.lat == 3'h1) begin
                            n.bstate = FBR_B_DATA;
                        end else begin
                            n.lat = s.lat - 3'h1;
                        end
                    end
                end
                FBR_B_DATA: begin
                    // halted clock or disabled output freezes the word
                    if (hclk_edge && !i_out_en_n) begin // see RL16 see RL18
                        n.addr = burst_step(s.addr, s.rcfg_len); // see RL1 see RL2
                    end
                end
                default: n.bstate = FBR_B_IDLE;
            endcase
        end

        // data source for the addressed partition
        cur_mode = s.mode[part_of(s.addr)]; // see RL10
        case (cur_mode)
            FBR_MODE_ARRAY: src = i_array_data;
            FBR_MODE_IDENT: src = i_info_data; // see RL3
            FBR_MODE_QUERY: src = {8'h00, i_info_data[7:0]}; // see RL4
            FBR_MODE_STATUS: src = {8'h00, s.status[part_of(s.addr)]}; // see RL5
            default: src = i_array_data;
        endcase
        // sensing keeps running while suspended; the output word stays put
        if (s.bstate != FBR_B_DATA || !i_out_en_n) begin // see RL17
            n.data_out = src;
        end
        n.array_addr = n.addr; // see RL17
        n.info_sel = cur_mode;
        n.data_oe = ~i_chip_sel_n & ~i_out_en_n & i_write_en_n & s.out_ok; // see RL11 see RL20 see RL25
        n.wait_oe = ~i_chip_sel_n & s.out_ok; // see RL19
        // busy unless a synchronous array burst is delivering
        n.wait_busy = ~(s.rcfg_sync & (cur_mode == FBR_MODE_ARRAY)
            & (n.bstate == FBR_B_DATA)); // see RL6 see RL7
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
            for (int p = 0; p < `FBR_NPART; p++) begin
                s.mode[p] <= FBR_MODE_ARRAY; // see RL9
                s.status[p] <= `FBR_SR_RESET; // see RL9
            end
            s.rcfg_sync <= 1'b0; // see RL9
            s.bstate <= FBR_B_IDLE;
            s.info_sel <= FBR_MODE_ARRAY;
            s.hclk_q <= 1'b1;
            s.adv_q <= 1'b1;
            s.we_q <= 1'b1;
            s.wait_busy <= 1'b1;
            s.write_ready <= 1'b1;
            s.abort <= 1'b1; // see RL22
        end else begin
            s <= n;
        end
    end

    assign o_data = s.data_out;
    assign o_data_oe = s.data_oe;
    assign o_wait = s.wait_busy;
    assign o_wait_oe = s.wait_oe;
    assign o_array_addr = s.array_addr;
    assign o_info_sel = s.info_sel;
    assign o_cmd_valid = s.buf_vld[0];
    assign o_cmd_addr = s.buf_addr[0];
    assign o_cmd_data = s.buf_data[0];
    assign o_write_ready = s.write_ready;
    assign o_engine_abort = s.abort;
endmodule
`default_nettype wire

// ===== verif/fbr_src_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbr_cfg.svh"
module fbr_src_model (
    // array side
    input wire logic [`FBR_ADDR_W-1:0] i_addr,
    output logic [`FBR_DATA_W-1:0] o_array_data,
    output logic [`FBR_DATA_W-1:0] o_info_data,
    // engine side
    input wire logic i_stall,
    output logic o_cmd_ready
);
    // same-cycle source; info high byte zero, query data is byte wide
    assign o_array_data = i_addr[15:0] ^ 16'h5a5a;
    assign o_info_data = {8'h00, i_addr[7:0] ^ 8'h3c};
    assign o_cmd_ready = !i_stall;
endmodule
`default_nettype wire

// ===== verif/fbr_bus_props.sv
`timescale 1ns/1ps
`default_nettype none
module fbr_bus_props #(
    parameter int OUT_DELAY_NS = 150
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_chip_sel_n,
    input wire logic i_out_en_n,
    input wire logic i_write_en_n,
    input wire logic o_data_oe,
    input wire logic o_wait_oe,
    input wire logic o_cmd_valid,
    input wire logic o_write_ready,
    input wire logic o_engine_abort
);
    localparam int OUT_CYC = (OUT_DELAY_NS + 99) / 100;
    logic [3:0] up;
    logic awake;
    // margin of three edges past the wake-up delay
    assign awake = up >= 4'(OUT_CYC + 3);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up <= 4'h0;
        end else if (up != 4'hf) begin
            up <= up + 4'h1;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence s_read;
        awake && !i_chip_sel_n && !i_out_en_n && i_write_en_n;
    endsequence
    sequence s_wr_rise;
        awake && o_write_ready && $rose(i_write_en_n) && !i_chip_sel_n && i_out_en_n;
    endsequence
    property p_reset_float;
        $rose(i_rst_n) |-> !o_data_oe && !o_wait_oe;
    endproperty
    property p_standby;
        i_chip_sel_n |=> !o_data_oe && !o_wait_oe;
    endproperty
    property p_out_disable;
        !i_chip_sel_n && i_out_en_n && i_write_en_n |=> !o_data_oe;
    endproperty
    property p_write_float;
        !i_write_en_n |=> !o_data_oe;
    endproperty
    property p_wait_cs;
        o_wait_oe && !i_chip_sel_n |=> o_wait_oe;
    endproperty
    property p_abort;
        $rose(i_rst_n) |-> ##[1:2] !o_engine_abort ##1 !o_engine_abort [*3];
    endproperty
    property p_wr_accept;
        s_wr_rise |=> o_cmd_valid;
    endproperty
    property p_read_drive;
        s_read [*4] |-> o_data_oe;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("outputs driven at wake");
    a_standby: assert property (p_standby) else $error("driven while deselected");
    a_out_disable: assert property (p_out_disable) else $error("data driven, oe off");
    a_write_float: assert property (p_write_float) else $error("data driven in write");
    a_wait_cs: assert property (p_wait_cs) else $error("wait floated under cs");
    a_abort: assert property (p_abort) else $error("abort not cleared");
    a_wr_accept: assert property (p_wr_accept) else $error("write not buffered");
    a_read_drive: assert property (p_read_drive) else $error("read not driven");
endmodule
bind fbr_flash_bus fbr_bus_props #(.OUT_DELAY_NS(OUT_DELAY_NS)) u_fbr_bus_props (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_chip_sel_n(i_chip_sel_n),
    .i_out_en_n(i_out_en_n), .i_write_en_n(i_write_en_n), .o_data_oe(o_data_oe),
    .o_wait_oe(o_wait_oe), .o_cmd_valid(o_cmd_valid), .o_write_ready(o_write_ready),
    .o_engine_abort(o_engine_abort));
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbr_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
    import fbr_pkg::*;
    logic clk, rst_n, hclk, adv_n, cs_n, oe_n, we_n, ld, sy, swe, stall, fl;
    logic dq_oe, wt, wt_oe, cv, crdy, wrdy, abrt;
    logic [1:0] ln;
    logic [2:0] sp;
    logic [7:0] sv;
    logic [20:0] addr, aa, ca;
    logic [15:0] din, dq, adat, idat, cd;
    fbr_mode_t isel;
    int miscompares = 0;
    int num_checks = 0;
    fbr_flash_bus u_fbr_flash_bus (.i_mclk(clk), .i_rst_n(rst_n), .i_host_clk(hclk),
        .i_address_valid_n(adv_n), .i_chip_sel_n(cs_n), .i_out_en_n(oe_n),
        .i_write_en_n(we_n), .i_addr(addr), .i_data(din), .o_data(dq), .o_data_oe(dq_oe),
        .o_wait(wt), .o_wait_oe(wt_oe), .i_rcfg_load(ld), .i_rcfg_sync(sy),
        .i_rcfg_fall(fl), .i_rcfg_len(ln), .o_array_addr(aa), .o_info_sel(isel),
        .i_array_data(adat), .i_info_data(idat), .i_status_we(swe), .i_status_part(sp),
        .i_status_val(sv), .o_cmd_valid(cv), .o_cmd_addr(ca), .o_cmd_data(cd),
        .i_cmd_ready(crdy), .o_write_ready(wrdy), .o_engine_abort(abrt));
    fbr_src_model u_fbr_src_model (.i_addr(aa), .o_array_data(adat), .o_info_data(idat),
        .i_stall(stall), .o_cmd_ready(crdy));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [15:0] arr(input logic [20:0] a);
        return a[15:0] ^ 16'h5a5a;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [20:0] a, input logic [15:0] d);
        addr = a; din = d; cs_n = 0; oe_n = 1; adv_n = 0; we_n = 0;
        cyc(2);
        we_n = 1; adv_n = 1;
        cyc(1);
        cs_n = 1;
        cyc(2);
    endtask
    task automatic rd(input logic [20:0] a, input logic [15:0] e, input fbr_mode_t m);
        addr = a; adv_n = 0; cs_n = 0; oe_n = 0; we_n = 1;
        cyc(1);
        adv_n = 1; addr = ~a;
        cyc(3);
        `CHK(dq_oe, 1'b1)
        `CHK(dq, e)
        `CHK(isel, m)
        if (m != FBR_MODE_ARRAY) `CHK(wt, 1'b1)
        oe_n = 1;
        cyc(2);
        `CHK(dq_oe, 1'b0)
        `CHK(wt_oe, 1'b1)
        cs_n = 1;
        cyc(2);
        `CHK(wt_oe, 1'b0)
    endtask
    task automatic in_reset;
        `CHK(dq_oe | wt_oe, 1'b0)
        `CHK(abrt, 1'b1)
        `CHK(isel, FBR_MODE_ARRAY)
        `CHK({wrdy, cv}, 2'b10)
    endtask
    task automatic t_modes;
        logic [7:0] cmd [4];
        fbr_mode_t md [4];
        logic [15:0] ex [4];
        logic [20:0] a;
        a = 21'h0c0014;
        cmd = '{8'h90, 8'h98, 8'h70, 8'hff};
        md = '{FBR_MODE_IDENT, FBR_MODE_QUERY, FBR_MODE_STATUS, FBR_MODE_ARRAY};
        ex = '{{8'h00, 8'h14 ^ 8'h3c}, {8'h00, 8'h14 ^ 8'h3c}, 16'h0080, arr(a)};
        for (int i = 0; i < 4; i++) begin
            wr(a, {8'h00, cmd[i]});
            rd(a, ex[i], md[i]);
            rd(a ^ 21'h040000, arr(a ^ 21'h040000), FBR_MODE_ARRAY);
        end
        sp = 3'h3; sv = 8'h9c; swe = 1;
        cyc(1);
        swe = 0;
        wr(a, 16'h0070);
        rd(a, 16'h009c, FBR_MODE_STATUS);
        wr(a, 16'h00ff);
    endtask
    task automatic t_buffer;
        stall = 1;
        wr(21'h000100, 16'h0040);
        wr(21'h000101, 16'h00d0);
        `CHK(wrdy, 1'b0)
        wr(21'h000102, 16'h0020);
        `CHK({ca, cd}, {21'h000100, 16'h0040})
        stall = 0;
        cyc(1);
        `CHK({ca, cd}, {21'h000101, 16'h00d0})
        cyc(1);
        `CHK(cv, 1'b0)
    endtask
    task automatic hedge;
        hclk = 0;
        cyc(3);
        hclk = 1;
        cyc(3);
    endtask
    task automatic t_burst;
        logic [20:0] a;
        a = 21'h040006;
        sy = 1; ln = `FBR_LEN_4; ld = 1;
        cyc(1);
        ld = 0; addr = a; cs_n = 0; oe_n = 0; adv_n = 0;
        cyc(2);
        for (int k = 0; k < 8 && wt !== 1'b0; k++) hedge;
        `CHK(wt, 1'b0)
        if (wt !== 1'b0) stop_test;
        `CHK(dq, arr(a))
        hedge;
        `CHK(dq, arr(a + 21'h1))
        oe_n = 1; // clock halted high: suspend
        cyc(6);
        `CHK({wt_oe, dq}, {1'b1, arr(a + 21'h1)})
        oe_n = 0;
        cyc(2);
        `CHK(dq, arr(a + 21'h1))
        hedge;
        `CHK(dq, arr(21'h040004))
        cs_n = 1; adv_n = 1; fl = 1; ld = 1;
        cyc(1);
        // falling host clock edge as the active edge
        ld = 0; addr = 21'h040002; cs_n = 0; oe_n = 0; adv_n = 0;
        cyc(2);
        for (int k = 0; k < 8 && wt !== 1'b0; k++) hedge;
        `CHK(wt, 1'b0)
        if (wt !== 1'b0) stop_test;
        `CHK(dq, arr(21'h040002))
        cs_n = 1; adv_n = 1; sy = 0; fl = 0; ld = 1;
        cyc(1);
        ld = 0;
        cyc(2);
    endtask
    initial begin
        rst_n = 0; hclk = 1; adv_n = 1; cs_n = 1; oe_n = 1; we_n = 1;
        ld = 0; sy = 0; fl = 0; swe = 0; stall = 0; ln = 2'h0; sp = 3'h0; sv = 8'h00;
        addr = '0; din = '0;
        cyc(8);
        in_reset;
        rst_n = 1;
        cyc(5);
        t_modes;
        t_buffer;
        t_burst;
        wr(21'h0c0014, 16'h0090);
        rst_n = 0; // 200 ns low
        cyc(2);
        in_reset;
        rst_n = 1;
        cyc(5);
        rd(21'h0c0014, arr(21'h0c0014), FBR_MODE_ARRAY);
        stop_test;
    end
endmodule
`default_nettype wire
